// ==== hw/cmirq_pkg.sv ====
// Package for the comparator mode and edge interrupt register block.
// Assumes an 8-bit special-function register port on the system clock.
package cmirq_pkg;
    localparam logic [7:0] CMIRQ_MODE_ADDR = 8'h89;
    localparam logic [7:0] CMIRQ_MODE_RESET = 8'h02;
    localparam logic [7:0] CMIRQ_MODE_WMASK = 8'h33;
    localparam int CMIRQ_RISE_IE_BIT = 5;
    localparam int CMIRQ_FALL_IE_BIT = 4;
    localparam int CMIRQ_MODE_HI_BIT = 1;
    localparam int CMIRQ_MODE_LO_BIT = 0;
    localparam logic [1:0] CMIRQ_RESP_FASTEST = 2'h0;
    localparam logic [1:0] CMIRQ_RESP_LOWPWR = 2'h3;

    typedef struct packed {
        logic rise_irq_enable;
        logic fall_irq_enable;
        logic [1:0] response_mode;
    } cmirq_mode_t;

    typedef struct packed {
        logic rise_edge_flag;
        logic fall_edge_flag;
    } cmirq_flags_t;
endpackage

// ==== hw/cmirq_sync.sv ====
// Three-stage synchroniser with agreement filter for the comparator output.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module cmirq_sync (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic out_q;
    logic out_d;

    always_comb begin
        stage_d = {stage_q[1:0], async_in};
        out_d = out_q;
        // The first stage is read only by the second stage.
        if (stage_q[1] == stage_q[2]) begin
            out_d = stage_q[2];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= 3'h0;
            out_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule
`default_nettype wire

// ==== hw/cmirq_top.sv ====
// Mode select and edge interrupt logic of the second voltage comparator.
// Assumes an 8-bit register port with a one-cycle write strobe and a
// combinational-address read that is returned registered a cycle later.
// Contract
// - Bits 7:6 and 3:2 of the mode register read zero and ignore writes.
// - Bit 5 gates the rising-edge interrupt.
// - Bit 4 gates the falling-edge interrupt.
// - Bits 1:0 drive the comparator response-time mode, 00 fastest.
// - A rising result sets the rise flag, a falling one the fall flag.
// - Edge flags stay set until software clears them.
// - With the comparator off its output reads low and no irq is made.
`timescale 1ns/100ps
`default_nettype none
module cmirq_top
    import cmirq_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic comparator_on,
    input wire logic comparator_raw,
    input wire logic rise_flag_clr,
    input wire logic fall_flag_clr,
    output logic comparator_result,
    output logic rise_edge_flag,
    output logic fall_edge_flag,
    output logic [1:0] response_mode,
    output logic comparator_irq
);
    cmirq_mode_t mode_q, mode_d;
    cmirq_flags_t flags_q, flags_d;
    logic [7:0] rdata_q, rdata_d;
    logic result_q, result_d;
    logic prev_q, prev_d;
    logic irq_q, irq_d;
    logic cmp_sync;
    // Reset image of the stored fields, cut out of the full register value
    // so that the reset read-back and the stored fields cannot drift apart.
    localparam cmirq_mode_t MODE_RESET_VAL = '{
        rise_irq_enable: CMIRQ_MODE_RESET[CMIRQ_RISE_IE_BIT],
        fall_irq_enable: CMIRQ_MODE_RESET[CMIRQ_FALL_IE_BIT],
        response_mode: CMIRQ_MODE_RESET[CMIRQ_MODE_HI_BIT:CMIRQ_MODE_LO_BIT]
    };

    cmirq_sync u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(comparator_raw),
        .sync_out(cmp_sync)
    );

    always_comb begin
        mode_d = mode_q;
        rdata_d = rdata_q;
        if (reg_wr && reg_addr == CMIRQ_MODE_ADDR) begin
            // Unused bit pairs are never stored.
            mode_d.rise_irq_enable = reg_wdata[CMIRQ_RISE_IE_BIT];
            mode_d.fall_irq_enable = reg_wdata[CMIRQ_FALL_IE_BIT];
            mode_d.response_mode =
                reg_wdata[CMIRQ_MODE_HI_BIT:CMIRQ_MODE_LO_BIT];
        end
        if (reg_rd) begin
            rdata_d = 8'h00;
            if (reg_addr == CMIRQ_MODE_ADDR) begin
                rdata_d[CMIRQ_RISE_IE_BIT] = mode_q.rise_irq_enable;
                rdata_d[CMIRQ_FALL_IE_BIT] = mode_q.fall_irq_enable;
                rdata_d[CMIRQ_MODE_HI_BIT:CMIRQ_MODE_LO_BIT] =
                    mode_q.response_mode;
            end
        end
    end

    always_comb begin
        // A disabled comparator is seen as low.
        result_d = comparator_on & cmp_sync;
        prev_d = result_q;
        flags_d = flags_q;
        // Clear first so that a same-cycle edge wins.
        if (rise_flag_clr) begin
            flags_d.rise_edge_flag = 1'b0;
        end
        if (fall_flag_clr) begin
            flags_d.fall_edge_flag = 1'b0;
        end
        if (result_q && !prev_q) begin
            flags_d.rise_edge_flag = 1'b1;
        end
        if (!result_q && prev_q) begin
            flags_d.fall_edge_flag = 1'b1;
        end
        irq_d = comparator_on &&
            ((flags_q.rise_edge_flag && mode_q.rise_irq_enable) ||
             (flags_q.fall_edge_flag && mode_q.fall_irq_enable));
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= MODE_RESET_VAL;
            flags_q <= cmirq_flags_t'(2'h0);
            rdata_q <= 8'h00;
            result_q <= 1'b0;
            prev_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            flags_q <= flags_d;
            rdata_q <= rdata_d;
            result_q <= result_d;
            prev_q <= prev_d;
            irq_q <= irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign comparator_result = result_q;
    assign rise_edge_flag = flags_q.rise_edge_flag;
    assign fall_edge_flag = flags_q.fall_edge_flag;
    assign response_mode = mode_q.response_mode;
    assign comparator_irq = irq_q;

    property p_unused_zero;
        @(posedge mclk) disable iff (!reset_n)
        reg_rd |=> (reg_rdata & ~CMIRQ_MODE_WMASK) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("Unused mode bits read nonzero.");

    property p_rise_gate;
        @(posedge mclk) disable iff (!reset_n)
        (comparator_on && rise_edge_flag && mode_q.rise_irq_enable)
            |=> comparator_irq;
    endproperty
    a_rise_gate: assert property (p_rise_gate)
        else $error("Rising irq not raised.");

    property p_fall_gate;
        @(posedge mclk) disable iff (!reset_n)
        (comparator_on && fall_edge_flag && mode_q.fall_irq_enable)
            |=> comparator_irq;
    endproperty
    a_fall_gate: assert property (p_fall_gate)
        else $error("Falling irq not raised.");

    property p_mode_write;
        @(posedge mclk) disable iff (!reset_n)
        (reg_wr && reg_addr == CMIRQ_MODE_ADDR)
            |=> response_mode == $past(reg_wdata[1:0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("Response mode not updated.");

    property p_rise_set;
        @(posedge mclk) disable iff (!reset_n)
        $rose(comparator_result) |=> rise_edge_flag;
    endproperty
    a_rise_set: assert property (p_rise_set)
        else $error("Rise flag not set.");

    property p_hold;
        @(posedge mclk) disable iff (!reset_n)
        (fall_edge_flag && !fall_flag_clr) |=> fall_edge_flag;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Fall flag cleared by hardware.");

    property p_off_low;
        @(posedge mclk) disable iff (!reset_n)
        !comparator_on |=> !comparator_result && !comparator_irq;
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("Disabled comparator active.");

    property p_irq_cause;
        @(posedge mclk) disable iff (!reset_n)
        comparator_irq |-> $past(
            (rise_edge_flag && mode_q.rise_irq_enable) ||
            (fall_edge_flag && mode_q.fall_irq_enable));
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("Irq without cause.");

    property p_fall_set;
        @(posedge mclk) disable iff (!reset_n)
        $fell(comparator_result) |=> fall_edge_flag;
    endproperty
    a_fall_set: assert property (p_fall_set)
        else $error("Fall flag not set.");

    property p_rise_hold;
        @(posedge mclk) disable iff (!reset_n)
        (rise_edge_flag && !rise_flag_clr) |=> rise_edge_flag;
    endproperty
    a_rise_hold: assert property (p_rise_hold)
        else $error("Rise flag cleared by hardware.");

    property p_rise_clear;
        @(posedge mclk) disable iff (!reset_n)
        (rise_flag_clr && !(comparator_result && !prev_q)) |=> !rise_edge_flag;
    endproperty
    a_rise_clear: assert property (p_rise_clear)
        else $error("Rise flag not cleared.");

    property p_fall_clear;
        @(posedge mclk) disable iff (!reset_n)
        (fall_flag_clr && !(!comparator_result && prev_q)) |=> !fall_edge_flag;
    endproperty
    a_fall_clear: assert property (p_fall_clear)
        else $error("Fall flag not cleared.");

    // A flag whose enable is off must never reach the request line.
    property p_no_cause;
        @(posedge mclk) disable iff (!reset_n)
        !((rise_edge_flag && mode_q.rise_irq_enable) ||
          (fall_edge_flag && mode_q.fall_irq_enable)) |=> !comparator_irq;
    endproperty
    a_no_cause: assert property (p_no_cause)
        else $error("Irq raised with gated flags.");

    property p_result_follow;
        @(posedge mclk) disable iff (!reset_n)
        comparator_on |=> comparator_result == $past(cmp_sync);
    endproperty
    a_result_follow: assert property (p_result_follow)
        else $error("Enabled result does not follow comparator.");
endmodule
`default_nettype wire

// ==== sim/cmirq_afe_model.sv ====
// Behavioural analog comparator front end for the mode register block.
// Assumes response_mode comes from the block and target from the bench.
`timescale 1ns/100ps
`default_nettype none
module cmirq_afe_model (
    input wire logic [1:0] response_mode,
    input wire logic target,
    output logic comparator_raw
);
    // Slower modes answer later, so mode 3 also stretches the bench waits.
    int dly_ns[4] = '{100, 175, 320, 1050};
    initial comparator_raw = 1'b0;
    always @(target) begin
        comparator_raw <= #(dly_ns[response_mode]) target;
    end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the comparator mode and edge interrupt block.
// Assumes the front end model drives the raw comparator output.
`timescale 1ns/100ps
`default_nettype none
module tb import cmirq_pkg::*;;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic comparator_on = 1'b0;
    logic rise_flag_clr = 1'b0;
    logic fall_flag_clr = 1'b0;
    logic tgt = 1'b0;
    logic [7:0] reg_rdata;
    logic comparator_raw, comparator_result, comparator_irq;
    logic rise_edge_flag, fall_edge_flag;
    logic [1:0] response_mode;
    logic [7:0] st;
    int n_fail = 0;
    int checks = 0;
    assign st = {2'h0, comparator_irq, comparator_result, rise_edge_flag,
                 fall_edge_flag, response_mode};
    always #10 mclk = ~mclk;
    cmirq_top i_cmirq_top (.mclk(mclk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .comparator_on(comparator_on), .comparator_raw(comparator_raw),
        .rise_flag_clr(rise_flag_clr), .fall_flag_clr(fall_flag_clr),
        .comparator_result(comparator_result),
        .rise_edge_flag(rise_edge_flag), .fall_edge_flag(fall_edge_flag),
        .response_mode(response_mode), .comparator_irq(comparator_irq));
    cmirq_afe_model i_cmirq_afe_model (.response_mode(response_mode),
        .target(tgt), .comparator_raw(comparator_raw));
    task report_and_stop;
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        #1;
        chk(reg_rdata, e);
    endtask
    task clr;
        @(posedge mclk);
        rise_flag_clr <= 1'b1;
        fall_flag_clr <= 1'b1;
        @(posedge mclk);
        rise_flag_clr <= 1'b0;
        fall_flag_clr <= 1'b0;
    endtask
    // The wait is bounded, so a flag that never sets still ends the step.
    task edge_to(input logic v);
        @(posedge mclk);
        tgt <= v;
        for (int i = 0; i < 120; i++) begin
            @(posedge mclk);
            #1;
            if ((v ? rise_edge_flag : fall_edge_flag) === 1'b1) break;
        end
        repeat (2) @(posedge mclk);
        #1;
    endtask
    initial begin
        #50us;
        n_fail++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk(st, 8'h02);
        rd(CMIRQ_MODE_ADDR, CMIRQ_MODE_RESET);
        wr(CMIRQ_MODE_ADDR, 8'hFF);
        rd(CMIRQ_MODE_ADDR, CMIRQ_MODE_WMASK);
        rd(8'h88, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(CMIRQ_MODE_ADDR, 8'(m));
            chk(st, 8'(m));
        end
        @(posedge mclk);
        comparator_on <= 1'b1;
        clr();
        wr(CMIRQ_MODE_ADDR, 8'h33);
        edge_to(1'b1);
        chk(st, 8'h3B);
        wr(CMIRQ_MODE_ADDR, 8'h13);
        repeat (2) @(posedge mclk);
        #1;
        chk(st, 8'h1B);
        edge_to(1'b0);
        chk(st, 8'h2F);
        wr(CMIRQ_MODE_ADDR, 8'h03);
        repeat (2) @(posedge mclk);
        #1;
        chk(st, 8'h0F);
        wr(CMIRQ_MODE_ADDR, 8'h13);
        repeat (2) @(posedge mclk);
        #1;
        chk(st, 8'h2F);
        @(posedge mclk);
        comparator_on <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk(st, 8'h0F);
        clr();
        edge_to(1'b1);
        chk(st, 8'h03);
        report_and_stop;
    end
endmodule
`default_nettype wire
